// ==== src/mamc_pkg.sv ====
package mamc_pkg;
   // ------------------------------------------------
   // register offsets
   // ------------------------------------------------
   localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
   localparam logic [7:0] ADDR_MASK_TWO = 8'h75;
   localparam logic [7:0] ADDR_LOW_ONE = 8'h76;
   localparam logic [7:0] ADDR_LOW_TWO = 8'h77;
   localparam logic [7:0] ADDR_CFG_THREE = 8'h78;
   // high-byte result registers, eight in a row
   localparam logic [7:0] ADDR_HIGH_BASE = 8'h20;
   localparam logic [7:0] ADDR_HIGH_SPAN = 8'h08;
   // ------------------------------------------------
   // reset values and field positions
   // ------------------------------------------------
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int MASK_ONE_ANY_BIT = 7;
   localparam int MASK_TWO_OVT_BIT = 1;
   localparam int MASK_TWO_F4P_BIT = 5;
   localparam logic [7:0] MASK_TWO_RO = 8'h02;
   localparam int CFG_ALERT_BIT = 0;
   localparam int CFG_OVH_EN_BIT = 1;
   localparam int CFG_FULL_SPEED_ON_OVERHEAT_BIT = 2;
   localparam int CFG_FAST_BIT = 3;
   localparam int CFG_STEADY_LSB = 4;
   localparam int LOW_FIELD_W = 2;
   localparam int GROUP_SIZE = 4;
   localparam logic [3:0] PWM_FULL = 4'hF;
   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int SLOW_MS = 1000;
   localparam int FAST_MS = 250;
   localparam int SLOW_CYC = SLOW_MS * (CLK_HZ / 1000);
   localparam int FAST_CYC = FAST_MS * (CLK_HZ / 1000);
   localparam int TICK_W = 26;
endpackage

// ==== src/mamc_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ------------------------------------------------
module mamc_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic [W-1:0] pin_i,
   input wire logic [W-1:0] rst_val_i,
   output logic [W-1:0] level_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] lvl_d;
   logic [1:0] fill_q;

   // only stages two and three are compared; stage one feeds stage two alone
   // idle value held until the chain carries real pin samples, so the
   // cleared chain never looks like an asserted pin after reset
   assign lvl_d = (fill_q == 2'h3) ? ((s2_q == s3_q) ? s3_q : lvl_q) : rst_val_i;
   assign level_o = lvl_q;

   // chain and filtered level; idle value taken after reset release
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
         fill_q <= 2'h0;
      end
      else if (en_i)
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         fill_q <= (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ==== src/mamc_snap.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// high-byte result store, registered read
// ------------------------------------------------
module mamc_snap (
   input wire logic sys_clk_i,
   input wire logic en_i,
   input wire logic wr_i,
   input wire logic [2:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [2:0] rd_addr_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem_q [0:7];
   logic [7:0] rd_q;

   assign rd_data_o = rd_q;

   // no reset: contents are undefined until the engine writes them
   always_ff @(posedge sys_clk_i)
   begin
      if (en_i)
      begin
         if (wr_i)
         begin
            mem_q[wr_addr_i] <= wr_data_i;
         end
         rd_q <= mem_q[rd_addr_i];
      end
   end
endmodule
`default_nettype wire

// ==== src/mamc_top.sv ====
// Contract
// (RQ1) mask one bits 0-6 gate channel alerts
// (RQ2) mask one bit 7 gates status two
// (RQ3) mask two bit 0 gates 12 V
// (RQ4) overtemp mask bit is read-only
// (RQ5) mask two bits 2-4 gate fans 1-3
// (RQ6) bit 5 gates fan 4 or timer
// (RQ7) bits 6-7 gate diode faults A, B
// (RQ8) low bits one: four voltage LSB pairs
// (RQ9) low bits two: 12 V and temperatures
// (RQ10) low read freezes group until high reads
// (RQ11) alert bit turns fan pin two alert
// (RQ12) overheat monitor on selected pin
// (RQ13) overheat assertion can start the timer
// (RQ14) full_speed_on_overheat forces all fans full duty; with the alert bit set, fan pin two is still held low
// (RQ15) fast bit: tach every 250 ms
// (RQ16) steady bits: continuous tach per input
// (RQ17) lock makes config three read-only
// (RQ18) config and masks reset to zero
// (RQ19) alert when unmasked status flag set
`timescale 1ns/10ps
`default_nettype none
module mamc_top #(
   parameter int SLOW_CYC = mamc_pkg::SLOW_CYC,
   parameter int FAST_CYC = mamc_pkg::FAST_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   input wire logic lock_i,
   input wire logic overheat_pin_select_i,
   input wire logic [7:0] status_one_i,
   input wire logic [7:0] status_two_i,
   input wire logic timer_event_i,
   input wire logic res_wr_i,
   input wire logic [2:0] res_ch_i,
   input wire logic [9:0] res_val_i,
   input wire logic fan_speed_input_d_n_i,
   input wire logic five_volt_pin_n_i,
   input wire logic [3:0] pwm_i,
   output logic [3:0] pwm_o,
   output logic pwm2_oe_o,
   output logic alert_o,
   output logic overheat_o,
   output logic overheat_start_o,
   output logic full_speed_o,
   output logic fast_tach_o,
   output logic [3:0] tach_start_o,
   output logic [3:0] steady_tach_o
);
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   // address falls in the high-byte result window
   function automatic logic hi_hit(input logic [7:0] a);
      hi_hit = (a >= mamc_pkg::ADDR_HIGH_BASE) &&
               (a < mamc_pkg::ADDR_HIGH_BASE + mamc_pkg::ADDR_HIGH_SPAN);
   endfunction

   // group of a channel: 0 = voltages, 1 = 12 V and temperatures
   function automatic logic grp_of(input logic [2:0] ch);
      grp_of = ch[2];
   endfunction

   // ------------------------------------------------
   // registers and state
   // ------------------------------------------------
   logic [7:0] mask_one_q;
   logic [7:0] mask_two_q;
   logic [7:0] cfg_three_q;
   logic [15:0] low_q;
   logic [15:0] low_d;
   logic [7:0] pend_q;
   logic [7:0] pend_d;
   logic [7:0] pend_clr;
   logic [7:0] pend_set;
   logic rd_p_q;
   logic [7:0] addr_p_q;
   logic [7:0] rdata_d;
   logic [7:0] hi_rdata;
   logic [mamc_pkg::TICK_W-1:0] tick_q;
   logic [mamc_pkg::TICK_W-1:0] tick_lim;
   logic tick_hit;
   logic [1:0] pins_s;
   logic overheat_q;

   // ------------------------------------------------
   // register decode
   // ------------------------------------------------
   logic wr_m1;
   logic wr_m2;
   logic wr_cfg;
   logic rd_low1;
   logic rd_low2;
   logic rd_hi;
   assign wr_m1 = reg_wr_i && (reg_addr_i == mamc_pkg::ADDR_MASK_ONE);
   assign wr_m2 = reg_wr_i && (reg_addr_i == mamc_pkg::ADDR_MASK_TWO);
   assign wr_cfg = reg_wr_i && (reg_addr_i == mamc_pkg::ADDR_CFG_THREE)
                   && !lock_i; // see (RQ17)
   assign rd_low1 = reg_rd_i && (reg_addr_i == mamc_pkg::ADDR_LOW_ONE);
   assign rd_low2 = reg_rd_i && (reg_addr_i == mamc_pkg::ADDR_LOW_TWO);
   assign rd_hi = reg_rd_i && hi_hit(reg_addr_i);

   // mask and config registers, zero after reset
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mask_one_q <= mamc_pkg::RST_MASK; // see (RQ18)
         mask_two_q <= mamc_pkg::RST_MASK; // see (RQ18)
         cfg_three_q <= mamc_pkg::RST_CFG; // see (RQ18)
      end
      else if (en_i)
      begin
         if (wr_m1)
         begin
            mask_one_q <= reg_wdata_i;
         end
         if (wr_m2)
         begin
            // overtemp mask stays at its reset value
            mask_two_q <= reg_wdata_i & ~mamc_pkg::MASK_TWO_RO; // see (RQ4)
         end
         if (wr_cfg)
         begin
            cfg_three_q <= reg_wdata_i;
         end
      end
   end

   // ------------------------------------------------
   // result snapshots and freeze
   // ------------------------------------------------
   // a read of a low-bits register arms all four high bytes of its group;
   // the group stays frozen until each of those has been read
   assign pend_clr = rd_hi ? (8'h01 << reg_addr_i[2:0]) : 8'h00; // see (RQ10)
   assign pend_set = {{mamc_pkg::GROUP_SIZE{rd_low2}}, {mamc_pkg::GROUP_SIZE{rd_low1}}};
   assign pend_d = (pend_q & ~pend_clr) | pend_set; // see (RQ10)

   logic grp_frozen;
   logic res_take;
   assign grp_frozen = grp_of(res_ch_i) ? (|pend_q[7:4]) : (|pend_q[3:0]);
   assign res_take = res_wr_i && !grp_frozen; // see (RQ10)

   // channel n keeps its two LSBs at bits 2n+1:2n
   always_comb
   begin
      low_d = low_q;
      if (res_take)
      begin
         low_d[res_ch_i*mamc_pkg::LOW_FIELD_W +: mamc_pkg::LOW_FIELD_W] =
            res_val_i[1:0]; // see (RQ8) see (RQ9)
      end
   end

   // freeze flags and low-bit fields
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_q <= 8'h00;
         low_q <= 16'h0000;
      end
      else if (en_i)
      begin
         pend_q <= pend_d;
         low_q <= low_d;
      end
   end

   // high bytes live in a small store with a registered read
   mamc_snap mamc_snap_i (
      .sys_clk_i(sys_clk_i),
      .en_i(en_i),
      .wr_i(res_take),
      .wr_addr_i(res_ch_i),
      .wr_data_i(res_val_i[9:2]),
      .rd_addr_i(reg_addr_i[2:0]),
      .rd_data_o(hi_rdata)
   );

   // ------------------------------------------------
   // read path: two cycles, matching the store latency
   // ------------------------------------------------
   // low-bit registers are read-only; unmapped reads return zero
   always_comb
   begin
      rdata_d = mamc_pkg::RST_BYTE;
      if (hi_hit(addr_p_q))
      begin
         rdata_d = hi_rdata;
      end
      else
      begin
         case (addr_p_q)
            mamc_pkg::ADDR_MASK_ONE: rdata_d = mask_one_q;
            mamc_pkg::ADDR_MASK_TWO: rdata_d = mask_two_q;
            mamc_pkg::ADDR_LOW_ONE: rdata_d = low_q[7:0]; // see (RQ8)
            mamc_pkg::ADDR_LOW_TWO: rdata_d = low_q[15:8]; // see (RQ9)
            mamc_pkg::ADDR_CFG_THREE: rdata_d = cfg_three_q;
            default: rdata_d = mamc_pkg::RST_BYTE;
         endcase
      end
   end

   // read pipeline and answer
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rd_p_q <= 1'b0;
         addr_p_q <= 8'h00;
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end
      else if (en_i)
      begin
         rd_p_q <= reg_rd_i;
         addr_p_q <= reg_addr_i;
         reg_rvalid_o <= rd_p_q;
         if (rd_p_q)
         begin
            reg_rdata_o <= rdata_d;
         end
      end
   end

   // ------------------------------------------------
   // alert combining
   // ------------------------------------------------
   logic use_fan_speed_input_d;
   logic [7:0] stat_two_eff;
   logic alert_d;
   assign use_fan_speed_input_d = cfg_three_q[mamc_pkg::CFG_OVH_EN_BIT] && !overheat_pin_select_i;
   // bit 5 flags the overheat timer instead of fan 4 when tach four is borrowed
   always_comb
   begin
      stat_two_eff = status_two_i;
      stat_two_eff[mamc_pkg::MASK_TWO_F4P_BIT] =
         use_fan_speed_input_d ? timer_event_i : status_two_i[mamc_pkg::MASK_TWO_F4P_BIT]; // see (RQ6)
   end
   // status one bit 7 only summarises status two, so it is not used directly
   assign alert_d = (|(status_one_i[6:0] & ~mask_one_q[6:0])) // see (RQ1) see (RQ19)
      || (!mask_one_q[mamc_pkg::MASK_ONE_ANY_BIT] // see (RQ2)
          && (|(stat_two_eff & ~mask_two_q))); // see (RQ3) see (RQ5) see (RQ7)

   // ------------------------------------------------
   // overheat input
   // ------------------------------------------------
   mamc_sync #(
      .W(2)
   ) mamc_sync_i (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .en_i(en_i),
      .pin_i({five_volt_pin_n_i, fan_speed_input_d_n_i}),
      .rst_val_i(2'b11),
      .level_o(pins_s)
   );

   logic ovh_act;
   logic full_speed_on_overheat;
   // pins are active low; selection follows the external select bit
   assign ovh_act = cfg_three_q[mamc_pkg::CFG_OVH_EN_BIT] // see (RQ12)
      && !(overheat_pin_select_i ? pins_s[1] : pins_s[0]);
   assign full_speed_on_overheat = cfg_three_q[mamc_pkg::CFG_FULL_SPEED_ON_OVERHEAT_BIT] && ovh_act; // see (RQ14)

   // ------------------------------------------------
   // tach measurement cadence
   // ------------------------------------------------
   logic fast;
   assign fast = cfg_three_q[mamc_pkg::CFG_FAST_BIT];
   assign tick_lim = fast ? mamc_pkg::TICK_W'(FAST_CYC - 1)
                          : mamc_pkg::TICK_W'(SLOW_CYC - 1); // see (RQ15)
   // >= so a switch to fast mid-interval does not wait a full wrap
   assign tick_hit = (tick_q >= tick_lim);

   // interval counter
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         tick_q <= '0;
      end
      else if (en_i)
      begin
         tick_q <= tick_hit ? '0 : tick_q + 1'b1;
      end
   end

   // ------------------------------------------------
   // outputs, all registered
   // ------------------------------------------------
   logic alert_mode;
   logic [3:0] steady;
   logic [3:0] pwm_d;
   assign alert_mode = cfg_three_q[mamc_pkg::CFG_ALERT_BIT];
   assign steady = cfg_three_q[mamc_pkg::CFG_STEADY_LSB +: 4];
   // fan pin two: open-drain alert pulled low when active, else fan drive
   always_comb
   begin
      pwm_d = full_speed_on_overheat ? mamc_pkg::PWM_FULL : pwm_i; // see (RQ14)
      if (alert_mode)
      begin
         pwm_d[1] = 1'b0; // see (RQ11)
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pwm_o <= 4'h0;
         pwm2_oe_o <= 1'b1;
         alert_o <= 1'b0;
         overheat_q <= 1'b0;
         overheat_start_o <= 1'b0;
         full_speed_o <= 1'b0;
         fast_tach_o <= 1'b0;
         tach_start_o <= 4'h0;
         steady_tach_o <= 4'h0;
      end
      else if (en_i)
      begin
         pwm_o <= pwm_d;
         pwm2_oe_o <= alert_mode ? alert_d : 1'b1; // see (RQ11) see (RQ19)
         alert_o <= alert_d; // see (RQ19)
         overheat_q <= ovh_act;
         overheat_start_o <= ovh_act && !overheat_q; // see (RQ13)
         full_speed_o <= full_speed_on_overheat;
         fast_tach_o <= fast;
         tach_start_o <= {4{tick_hit}} | steady; // see (RQ15) see (RQ16)
         steady_tach_o <= steady; // see (RQ16)
      end
   end

   assign overheat_o = overheat_q;
endmodule
`default_nettype wire

// ==== verification/mamc_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// port checks of the read path, masks, alert, overheat and tach outputs
// ------------------------------------------------
module mamc_properties #(
   parameter int SLOW_CYC = 40,
   parameter int FAST_CYC = 10
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic en_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic reg_rvalid_o,
   input wire logic [7:0] status_one_i,
   input wire logic [7:0] status_two_i,
   input wire logic timer_event_i,
   input wire logic [3:0] pwm_o,
   input wire logic pwm2_oe_o,
   input wire logic alert_o,
   input wire logic overheat_o,
   input wire logic overheat_start_o,
   input wire logic full_speed_o,
   input wire logic [3:0] tach_start_o,
   input wire logic [3:0] steady_tach_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   logic [31:0] gap_q;
   logic [31:0] gap_d;
   // cycles since the last tach pulse; frozen clock restarts it, never overstates
   assign gap_d = (tach_start_o[0] || !en_i) ? 32'h0 : gap_q + 32'h1;
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         gap_q <= 32'h0;
      else
         gap_q <= gap_d;
   end
   read_latency_a: assert property ((reg_rd_i && en_i) ##1 en_i |=> reg_rvalid_o)
      else $error("read answer late");
   answer_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
      else $error("read answer without request");
   ovt_bit_ro_a: assert property (
      reg_rvalid_o && $past(reg_addr_i, 2) == 8'h75 |-> !reg_rdata_o[1])
      else $error("overtemp mask bit reads set");
   quiet_no_alert_a: assert property (
      status_one_i[6:0] == 7'h0 && status_two_i == 8'h0 && !timer_event_i |=> !alert_o)
      else $error("alert without flag");
   oe_low_idle_a: assert property (!pwm2_oe_o |-> !alert_o && !pwm_o[1])
      else $error("pin two released while alert");
   full_speed_on_overheat_full_a: assert property (
      full_speed_o ##1 full_speed_o |-> (pwm_o | 4'h2) == 4'hF)
      else $error("full_speed_on_overheat without full duty");
   start_pulse_a: assert property (overheat_start_o |=> !overheat_start_o)
      else $error("timer start longer than a cycle");
   start_cause_a: assert property (overheat_start_o |-> ##[0:1] overheat_o)
      else $error("timer start without overheat");
   steady_held_a: assert property ((steady_tach_o & ~tach_start_o) == 4'h0)
      else $error("steady tach dropped");
   tach_gap_a: assert property (gap_q < SLOW_CYC + 2)
      else $error("tach interval too long");
endmodule
bind mamc_top mamc_properties #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) mamc_properties_i (.*);
`default_nettype wire

// ==== verification/mamc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------
// host side of the register transaction layer
// ------------------------------------------------
module mamc_host (
   input wire logic sys_clk_i,
   input wire logic [7:0] rdata_i,
   input wire logic rvalid_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // idle bus before the first transfer
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // strobes are one-cycle pulses; released lines are inverted so nothing lingers
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge sys_clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // address held until the answer edge; a missing answer yields unknown data
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      int k;
      @(posedge sys_clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge sys_clk_i);
      rd_o <= 1'b0;
      k = 0;
      while (rvalid_i !== 1'b1 && k < 8)
      begin
         @(posedge sys_clk_i);
         k++;
      end
      d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
      addr_o <= ~a;
   endtask
endmodule
`default_nettype wire

// ==== verification/monitor_alert_mask_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module monitor_alert_mask_config_tb;
   logic sys_clk_i = 1'b0;
   logic nrst_i, en_i, reg_wr_i, reg_rd_i, reg_rvalid_o, lock_i, overheat_pin_select_i;
   logic timer_event_i, res_wr_i, fan_speed_input_d_n_i, five_volt_pin_n_i, pwm2_oe_o;
   logic alert_o, overheat_o, overheat_start_o, full_speed_o, fast_tach_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_one_i, status_two_i, rd_v, a_v;
   logic [2:0] res_ch_i;
   logic [9:0] res_val_i;
   logic [3:0] pwm_i, pwm_o, tach_start_o, steady_tach_o;
   int bad_count = 0;
   int total_checks = 0;
   int n;
   // ------------------------------------------------
   // clock, design and host
   // ------------------------------------------------
   initial
   begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   mamc_top #(.SLOW_CYC(40), .FAST_CYC(10)) mamc_top_i (.*);
   mamc_host mamc_host_i (.sys_clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o),
      .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i));
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      mamc_host_i.read(a, rd_v);
      check(rd_v, exp);
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge sys_clk_i);
   endtask
   task automatic put(input logic [2:0] ch, input logic [9:0] v);
      @(posedge sys_clk_i);
      res_wr_i <= 1'b1;
      res_ch_i <= ch;
      res_val_i <= v;
      @(posedge sys_clk_i);
      res_wr_i <= 1'b0;
   endtask
   // pulses on fan two over a window that holds whole periods of either rate
   task automatic count_tach(input logic [7:0] exp);
      n = 0;
      settle(1); // skip the pulse launched under the previous setting
      repeat (80)
      begin
         @(posedge sys_clk_i);
         n += int'(tach_start_o[1]);
      end
      check(8'(n), exp);
   endtask
   task automatic summarize;
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog, about thirty times the expected run
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      bad_count++;
      summarize();
   end
   // ------------------------------------------------
   // test sequence
   // ------------------------------------------------
   initial
   begin
      nrst_i = 1'b0;
      en_i = 1'b1;
      lock_i = 1'b0;
      overheat_pin_select_i = 1'b1;
      timer_event_i = 1'b0;
      {status_two_i, status_one_i} = 16'h0;
      {res_wr_i, res_ch_i, res_val_i} = 14'h0;
      fan_speed_input_d_n_i = 1'b1;
      five_volt_pin_n_i = 1'b1;
      pwm_i = 4'h5;
      settle(20);
      nrst_i <= 1'b1;
      settle(6);
      rd_chk(8'h74, 8'h00);
      rd_chk(8'h75, 8'h00);
      rd_chk(8'h78, 8'h00);
      rd_chk(8'h7F, 8'h00);
      // each flag but status one bit 7 raises alert, its own mask bit silences it (overtemp bit cannot)
      for (int i = 0; i < 16; i++)
      begin
         if (i == 7)
            continue;
         a_v = (i < 8) ? 8'h74 : 8'h75;
         {status_two_i, status_one_i} <= 16'h1 << i;
         settle(3);
         check({7'h0, alert_o}, 8'h01);
         mamc_host_i.write(a_v, 8'h1 << (i % 8));
         settle(3);
         check({7'h0, alert_o}, {7'h0, i == 9});
         rd_chk(a_v, (i == 9) ? 8'h00 : 8'h1 << (i % 8));
         mamc_host_i.write(a_v, 8'h00);
      end
      {status_two_i, status_one_i} <= 16'hFD00;
      settle(3);
      check({7'h0, alert_o}, 8'h01);
      mamc_host_i.write(8'h74, 8'h80);
      settle(3);
      check({7'h0, alert_o}, 8'h00);
      mamc_host_i.write(8'h74, 8'h00);
      mamc_host_i.write(8'h78, 8'h01);
      settle(3);
      check({6'h0, pwm2_oe_o, pwm_o[1]}, 8'h02);
      status_two_i <= 8'h00;
      settle(3);
      check({6'h0, pwm2_oe_o, pwm_o[1]}, 8'h00);
      // overheat pin ignored until monitoring is enabled
      mamc_host_i.write(8'h78, 8'h00);
      five_volt_pin_n_i <= 1'b0;
      settle(8);
      check({7'h0, overheat_o}, 8'h00);
      mamc_host_i.write(8'h78, 8'h06);
      n = 0;
      repeat (10)
      begin
         @(posedge sys_clk_i);
         n += int'(overheat_start_o);
      end
      check(8'(n), 8'h01);
      check({2'h0, overheat_o, full_speed_o, pwm_o}, 8'h3F);
      mamc_host_i.write(8'h78, 8'h02);
      settle(3);
      check({2'h0, overheat_o, full_speed_o, pwm_o}, 8'h25);
      five_volt_pin_n_i <= 1'b1;
      settle(8);
      check({2'h0, overheat_o, full_speed_o, pwm_o}, 8'h05);
      // tach four borrowed: its pin is the overheat input, bit 5 flags the timer
      {overheat_pin_select_i, fan_speed_input_d_n_i, timer_event_i} <= 3'b001;
      settle(8);
      check({6'h0, overheat_o, alert_o}, 8'h03);
      mamc_host_i.write(8'h75, 8'h20);
      settle(3);
      check({6'h0, overheat_o, alert_o}, 8'h02);
      mamc_host_i.write(8'h75, 8'h00);
      {overheat_pin_select_i, fan_speed_input_d_n_i, timer_event_i} <= 3'b110;
      settle(8);
      mamc_host_i.write(8'h78, 8'hF0);
      settle(2);
      check({steady_tach_o, tach_start_o}, 8'hFF);
      mamc_host_i.write(8'h78, 8'h00);
      count_tach(8'h02);
      mamc_host_i.write(8'h78, 8'h08);
      settle(2);
      check({7'h0, fast_tach_o}, 8'h01);
      count_tach(8'h08);
      lock_i <= 1'b1;
      mamc_host_i.write(8'h78, 8'hF1);
      rd_chk(8'h78, 8'h08);
      lock_i <= 1'b0;
      // low bits, freeze on read, release after all four high bytes
      for (int c = 0; c < 8; c++)
         put(3'(c), {8'h10 + 8'(c), 2'(c >> 1)});
      rd_chk(8'h76, 8'h50);
      rd_chk(8'h77, 8'hFA);
      put(3'h0, 10'h3FF);
      put(3'h4, 10'h3FF);
      for (int c = 0; c < 8; c++)
         rd_chk(8'h20 + 8'(c), 8'h10 + 8'(c));
      put(3'h0, 10'h3FF);
      put(3'h4, 10'h3FF);
      rd_chk(8'h20, 8'hFF);
      mamc_host_i.write(8'h76, 8'h00);
      rd_chk(8'h76, 8'h53);
      rd_chk(8'h77, 8'hFB);
      // mid-run reset brings mask one and config back to zero
      mamc_host_i.write(8'h74, 8'h7F);
      nrst_i <= 1'b0;
      settle(2);
      nrst_i <= 1'b1;
      settle(6);
      rd_chk(8'h74, 8'h00);
      rd_chk(8'h78, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
